// [vga_host_bus_interface.sv]
`timescale 1ns/10ps
// What this block does
// - bus-type strap at reset picks PC/AT or Micro Channel pin meanings
// - decode ROM window C0000 to C7FFF and drive the ROM chip select
// - ROM-width strap high means 16-bit ROM, low means 8-bit ROM
// - with 16-bit ROM, assert wide cycle indicator for ROM window addresses
// - ROM-enable strap low keeps ROM chip select inactive forever
// - after reset video memory accesses are 8-bit wide
// - once firmware enables 16-bit path, every video access is wide
// - host reaches up to one megabyte of video memory depending on mode
// - Micro Channel: I/O reads of 100 and 101 return adapter identity
// - Micro Channel: bit 0 of port 102 is a readable card-enable bit
// - card-selected feedback from address decode qualified by command
// - monochrome only: claim 3B0-3BF except 3B6, 3B7, 3BC, 3BD
// - color only: claim 3D0-3DF except 3D6, 3D7, 3DE, 3DF
// - always claim 3C0-3CF except 3CA, 3CB, 3CD
// - memory commands claim ROM window (when ROM-enable strap is high) and selected display window
// - card-selected feedback follows the command one clock edge after decode
// - CPU display memory writes queue in a FIFO and drain when memory bus is free
// - the queue lets host display memory writes finish without wait states while a slot is free
// - a 32-byte video cache feeds the screen while the CPU accesses memory
module vga_host_bus_interface #(
  parameter logic [15:0] ADAPTER_ID = 16'h5AA5, // arbitrary identity value
  parameter int          FIFO_DEPTH = vhb_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // configuration straps
  input  wire logic        bus_type_strap,
  input  wire logic        rom_width_strap,
  input  wire logic        rom_enable_strap,
  // host bus
  input  wire logic [19:0] hostAddr,
  input  wire logic        memCmd,
  input  wire logic        ioCmd,
  input  wire logic        hostWrite,
  input  wire logic [15:0] hostWdata,
  output logic [7:0]       ioRdata,
  output logic             ioRdataValid,
  output logic             wide_memory_cycle_indicator,
  output logic             cardSelFeedback,
  output logic             bios_rom_select,
  output logic             zeroWait,
  output logic             microChannel,
  output logic             cardEnabled,
  // display memory side
  input  wire logic        memBusFree,
  output logic             memWrValid,
  output logic [19:0]      memWrAddr,
  output logic [15:0]      memWrData,
  output logic             memWrWide,
  // screen refresh side
  input  wire logic        scanFetch,
  input  wire logic [4:0]  scanIndex,
  input  wire logic        scanLoad,
  input  wire logic [7:0]  scanLoadData,
  output logic [7:0]       scanPixel
);
  logic       strapWait;
  logic       strapMca;
  logic       strapWideRom;
  logic       strapRomOn;
  logic [7:0] cardCtl;
  logic [7:0] wideCtl;
  logic       romHit;
  logic       dispHit;
  logic       ioHit;
  logic       idHit;
  logic       memClaim;
  logic       ioClaim;
  logic [3:0] nib;
  logic [7:0] cache [vhb_pkg::CACHE_BYTES];
  logic       next_wide;
  vhb_fifo_if #(.AW(20), .DW(16)) wq ();

  // strap capture one edge after release; async reset loads constants only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strapWait    <= 1'b1;
      strapMca     <= 1'b0;
      strapWideRom <= 1'b0;
      strapRomOn   <= 1'b0;
    end else if (strapWait) begin
      strapWait    <= 1'b0;
      strapMca     <= !bus_type_strap;
      strapWideRom <= rom_width_strap;
      strapRomOn   <= rom_enable_strap;
    end
  end

  // address decode, purely combinational; feedback is registered one edge later
  assign nib     = hostAddr[3:0];
  assign romHit  = (hostAddr >= vhb_pkg::ROM_LO) && (hostAddr <= vhb_pkg::ROM_LAST);
  always_comb begin
    dispHit = 1'b0;
    if (wideCtl[vhb_pkg::LINEAR_BIT]) begin
      dispHit = !romHit && (hostAddr <= vhb_pkg::LINEAR_SPAN);
    end else if (hostAddr >= vhb_pkg::GFX_MEM_LO && hostAddr <= vhb_pkg::GFX_MEM_HI) begin
      dispHit = 1'b1;
    end else if (wideCtl[vhb_pkg::MONO_SEL_BIT]) begin
      dispHit = hostAddr >= vhb_pkg::MONO_MEM_LO && hostAddr <= vhb_pkg::MONO_MEM_HI;
    end else begin
      dispHit = hostAddr >= vhb_pkg::COLOR_MEM_LO && hostAddr <= vhb_pkg::COLOR_MEM_HI;
    end
  end
  always_comb begin
    ioHit = 1'b0;
    if (hostAddr[15:4] == vhb_pkg::ATTR_GROUP) begin
      ioHit = !vhb_pkg::ATTR_HOLES[nib];
    end else if (hostAddr[15:4] == vhb_pkg::MONO_GROUP) begin
      ioHit = wideCtl[vhb_pkg::MONO_SEL_BIT] && !vhb_pkg::MONO_HOLES[nib];
    end else if (hostAddr[15:4] == vhb_pkg::COLOR_GROUP) begin
      ioHit = !wideCtl[vhb_pkg::MONO_SEL_BIT] && !vhb_pkg::COLOR_HOLES[nib];
    end
  end
  assign idHit    = strapMca && (hostAddr[15:0] >= vhb_pkg::ADAPTER_ID_LOW_ADDR)
                    && (hostAddr[15:0] <= vhb_pkg::CARD_ENABLE_CONTROL_ADDR);
  assign memClaim = memCmd && ((romHit && strapRomOn) || dispHit);
  assign ioClaim  = ioCmd && ioHit;

  // wide cycle decision for the current address
  always_comb begin
    next_wide = 1'b0;
    if (romHit && strapRomOn) begin
      next_wide = strapWideRom;
    end else if (dispHit) begin
      next_wide = wideCtl[vhb_pkg::WIDE_EN_BIT];
    end
  end

  // bus feedback outputs, one flop after decode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wide_memory_cycle_indicator <= 1'b0;
      cardSelFeedback             <= 1'b0;
      bios_rom_select             <= 1'b0;
      zeroWait                    <= 1'b0;
      microChannel                <= 1'b0;
      cardEnabled                 <= 1'b0;
    end else begin
      wide_memory_cycle_indicator <= next_wide;
      cardSelFeedback <= memClaim || ioClaim;
      bios_rom_select <= memCmd && romHit && strapRomOn;
      zeroWait        <= memCmd && hostWrite && dispHit && wq.pushReady;
      microChannel    <= strapMca;
      // held low until the straps are known, so no false enable after reset
      cardEnabled     <= !strapWait && (!strapMca || cardCtl[vhb_pkg::CARD_EN_BIT]);
    end
  end

  // control registers written by host i/o
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cardCtl <= vhb_pkg::CARD_ENABLE_RESET;
      wideCtl <= vhb_pkg::WIDE_MODE_RESET;
    end else if (ioCmd && hostWrite) begin
      if (strapMca && hostAddr[15:0] == vhb_pkg::CARD_ENABLE_CONTROL_ADDR) begin
        cardCtl <= {7'h00, hostWdata[vhb_pkg::CARD_EN_BIT]};
      end
      if (hostAddr[15:0] == vhb_pkg::WIDE_MODE_CONTROL_ADDR) begin
        wideCtl <= {5'h00, hostWdata[2:0]};
      end
    end
  end

  // i/o read data; only the identity and control ports answer here
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ioRdata      <= 8'h00;
      ioRdataValid <= 1'b0;
    end else begin
      ioRdataValid <= ioCmd && !hostWrite
                      && (idHit || hostAddr[15:0] == vhb_pkg::WIDE_MODE_CONTROL_ADDR);
      unique case (hostAddr[15:0])
        vhb_pkg::ADAPTER_ID_LOW_ADDR:      ioRdata <= ADAPTER_ID[7:0];
        vhb_pkg::ADAPTER_ID_HIGH_ADDR:     ioRdata <= ADAPTER_ID[15:8];
        vhb_pkg::CARD_ENABLE_CONTROL_ADDR: ioRdata <= cardCtl;
        vhb_pkg::WIDE_MODE_CONTROL_ADDR:   ioRdata <= wideCtl;
        default:                           ioRdata <= 8'h00;
      endcase
    end
  end

  // host writes to display memory go into the queue, without wait states while a slot is free
  assign wq.pushValid = memCmd && hostWrite && dispHit;
  assign wq.pushAddr  = hostAddr;
  assign wq.pushData  = hostWdata;
  assign wq.pushWide  = wideCtl[vhb_pkg::WIDE_EN_BIT];
  assign wq.popReady  = memBusFree && !memWrValid;

  vhb_write_queue #(.DEPTH(FIFO_DEPTH), .AW(20), .DW(16)) u_queue (
    .sys_clk (sys_clk),
    .rst     (rst),
    .q       (wq)
  );

  // drain register: one memory write only on a free memory bus cycle, at most every other cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      memWrValid <= 1'b0;
      memWrAddr  <= 20'h0_0000;
      memWrData  <= 16'h0000;
      memWrWide  <= 1'b0;
    end else begin
      memWrValid <= wq.popValid && wq.popReady;
      if (wq.popValid && wq.popReady) begin
        memWrAddr <= wq.popAddr;
        memWrData <= wq.popData;
        memWrWide <= wq.popWide;
      end
    end
  end

  // video cache: refresh loads bytes, screen reads them while cpu uses memory
  always_ff @(posedge sys_clk) begin
    if (scanLoad) begin
      cache[scanIndex] <= scanLoadData;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scanPixel <= 8'h00;
    end else if (scanFetch) begin
      scanPixel <= cache[scanIndex];
    end
  end

  a_rom_gated: assert property (@(posedge sys_clk) disable iff (rst)
    (!strapRomOn && !strapWait) |=> !bios_rom_select)
    else $error("rom select while rom disabled");
  a_rom_select: assert property (@(posedge sys_clk) disable iff (rst)
    (memCmd && strapRomOn && hostAddr[19:15] == 5'h18) |=> bios_rom_select)
    else $error("rom window not selected");
  a_wide_rom: assert property (@(posedge sys_clk) disable iff (rst)
    (romHit && strapRomOn) |=> (wide_memory_cycle_indicator == $past(strapWideRom)))
    else $error("rom width indicator wrong");
  a_wide_video: assert property (@(posedge sys_clk) disable iff (rst)
    (dispHit && !romHit) |=> (wide_memory_cycle_indicator == $past(wideCtl[0])))
    else $error("video width indicator wrong");
  a_feedback_track: assert property (@(posedge sys_clk) disable iff (rst)
    (!memCmd && !ioCmd) |=> !cardSelFeedback)
    else $error("feedback without command");
  a_attr_hole: assert property (@(posedge sys_clk) disable iff (rst)
    (ioCmd && !memCmd && hostAddr[15:0] == 16'h03CD) |=> !cardSelFeedback)
    else $error("claimed excluded port");
  a_mono_claim: assert property (@(posedge sys_clk) disable iff (rst)
    (ioCmd && wideCtl[1] && hostAddr[15:0] == 16'h03B4) |=> cardSelFeedback)
    else $error("mono port not claimed");
  a_color_hole: assert property (@(posedge sys_clk) disable iff (rst)
    (ioCmd && !memCmd && hostAddr[15:0] == 16'h03DE) |=> !cardSelFeedback)
    else $error("claimed excluded color port");
  a_strap_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !strapWait && !$past(strapWait) |-> $stable(strapMca))
    else $error("strap changed after capture");
  a_id_read: assert property (@(posedge sys_clk) disable iff (rst)
    (strapMca && ioCmd && !hostWrite && hostAddr[15:0] == 16'h0100)
    |=> (ioRdataValid && ioRdata == ADAPTER_ID[7:0]))
    else $error("identity read wrong");
  c_rom_read: cover property (@(posedge sys_clk) bios_rom_select && wide_memory_cycle_indicator);
  c_queue_drain: cover property (@(posedge sys_clk) memWrValid && memWrWide);
  c_mca_enable: cover property (@(posedge sys_clk) microChannel && cardEnabled);
  c_io_claim: cover property (@(posedge sys_clk) ioCmd ##1 cardSelFeedback);
endmodule

// [vhb_pkg.sv]
package vhb_pkg;
  // host address decode windows
  localparam logic [19:0] ROM_BASE      = 20'hC_0000;
  localparam logic [19:0] ROM_LAST      = 20'hC_7FFF;
  localparam logic [19:0] ROM_LO        = 20'hC_0000;
  localparam logic [19:0] MONO_MEM_LO   = 20'hB_0000;
  localparam logic [19:0] MONO_MEM_HI   = 20'hB_7FFF;
  localparam logic [19:0] COLOR_MEM_LO  = 20'hB_8000;
  localparam logic [19:0] COLOR_MEM_HI  = 20'hB_FFFF;
  localparam logic [19:0] GFX_MEM_LO    = 20'hA_0000;
  localparam logic [19:0] GFX_MEM_HI    = 20'hA_FFFF;
  localparam logic [19:0] LINEAR_SPAN   = 20'hF_FFFF;
  // i/o register map
  localparam logic [15:0] ADAPTER_ID_LOW_ADDR      = 16'h0100;
  localparam logic [15:0] ADAPTER_ID_HIGH_ADDR     = 16'h0101;
  localparam logic [15:0] CARD_ENABLE_CONTROL_ADDR = 16'h0102;
  localparam logic [15:0] WIDE_MODE_CONTROL_ADDR   = 16'h03C3;
  localparam logic [11:0] MONO_GROUP   = 12'h03B;
  localparam logic [11:0] ATTR_GROUP   = 12'h03C;
  localparam logic [11:0] COLOR_GROUP  = 12'h03D;
  localparam int          CARD_EN_BIT  = 0;
  localparam int          WIDE_EN_BIT  = 0;
  localparam int          MONO_SEL_BIT = 1;
  localparam int          LINEAR_BIT   = 2;
  localparam logic [7:0]  CARD_ENABLE_RESET = 8'h00;
  localparam logic [7:0]  WIDE_MODE_RESET   = 8'h00;
  // excluded low nibbles inside each group, one bit per address
  localparam logic [15:0] MONO_HOLES  = 16'h3_0C0;
  localparam logic [15:0] COLOR_HOLES = 16'hC_0C0;
  localparam logic [15:0] ATTR_HOLES  = 16'h2_C00;
  // write queue and cache sizes
  localparam int FIFO_DEPTH  = 8;
  localparam int CACHE_BYTES = 32;
endpackage

// [vhb_fifo_if.sv]
`timescale 1ns/10ps
interface vhb_fifo_if #(parameter int AW = 20, parameter int DW = 16);
  logic          pushValid;
  logic          pushReady;
  logic [AW-1:0] pushAddr;
  logic [DW-1:0] pushData;
  logic          pushWide;
  logic          popValid;
  logic          popReady;
  logic [AW-1:0] popAddr;
  logic [DW-1:0] popData;
  logic          popWide;
  modport queue (input pushValid, pushAddr, pushData, pushWide, popReady,
                 output pushReady, popValid, popAddr, popData, popWide);
  modport user (output pushValid, pushAddr, pushData, pushWide, popReady,
                input pushReady, popValid, popAddr, popData, popWide);
endinterface

// [vhb_write_queue.sv]
`timescale 1ns/10ps
module vhb_write_queue #(
  parameter int DEPTH = 8,
  parameter int AW    = 20,
  parameter int DW    = 16
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // queue ports
  vhb_fifo_if.queue q
);
  localparam int PW = $clog2(DEPTH);
  localparam int EW = AW + DW + 1;

  logic [EW-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0]   fill;
  logic          doPush;
  logic          doPop;

  // host writes are taken whenever a slot is free, so no wait state
  assign q.pushReady = (fill != (PW+1)'(DEPTH));
  assign q.popValid  = (fill != '0);
  assign doPush      = q.pushValid && q.pushReady;
  assign doPop       = q.popValid && q.popReady;
  assign {q.popWide, q.popAddr, q.popData} = store[rdPtr];

  // storage array, written only on a taken push
  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      store[wrPtr] <= {q.pushWide, q.pushAddr, q.pushData};
    end
  end

  // pointers and fill level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      fill <= fill + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end

  a_fill_bound: assert property (@(posedge sys_clk) disable iff (rst)
    fill <= (PW+1)'(DEPTH)) else $error("queue fill beyond depth");
  a_no_loss: assert property (@(posedge sys_clk) disable iff (rst)
    (doPush && !doPop) |=> (fill == $past(fill) + 1'b1))
    else $error("pushed entry not counted");
endmodule

// [vhb_host_model.sv]
`timescale 1ns/10ps
// host processor stand-in: one command per call, held across exactly one edge
module vhb_host_model (
  // clock
  input  wire logic        sys_clk,
  // host bus drive
  output logic [19:0]      hostAddr,
  output logic             memCmd,
  output logic             ioCmd,
  output logic             hostWrite,
  output logic [15:0]      hostWdata
);
  // idle bus with no command pending
  initial begin
    hostAddr  = 20'h0_0000;
    memCmd    = 1'b0;
    ioCmd     = 1'b0;
    hostWrite = 1'b0;
    hostWdata = 16'h0000;
  end

  // drive after an edge, let one edge take it, then release
  task automatic cycle(input bit isMem, input bit wr, input logic [19:0] a,
                       input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    hostAddr  = a;
    memCmd    = isMem;
    ioCmd     = !isMem;
    hostWrite = wr;
    hostWdata = d;
    @(posedge sys_clk);
    #1;
    memCmd    = 1'b0;
    ioCmd     = 1'b0;
    hostWrite = 1'b0;
    // released lines show a changed pattern, not the stale value
    hostAddr  = ~a;
    hostWdata = ~d;
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/10ps
`define CHK(nm, got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; $display("unexpected %s exp %h got %h", nm, exp, got); end end
module testbench;
  localparam int QD = 8;
  logic        sys_clk, rst, busType, romWidth, romEnable, memBusFree;
  logic        scanFetch, scanLoad;
  logic [4:0]  scanIndex;
  logic [7:0]  scanLoadData, ioRdata, scanPixel;
  logic [19:0] hostAddr, memWrAddr;
  logic [15:0] hostWdata, memWrData;
  logic        memCmd, ioCmd, hostWrite, ioRdataValid, wideInd, cardSel, romSel;
  logic        zeroWait, microChannel, cardEnabled, memWrValid, memWrWide;
  int          errors, num_checks, n;

  vhb_host_model host_u (.sys_clk(sys_clk), .hostAddr(hostAddr), .memCmd(memCmd),
    .ioCmd(ioCmd), .hostWrite(hostWrite), .hostWdata(hostWdata));

  // identity value below is arbitrary
  vga_host_bus_interface #(.ADAPTER_ID(16'h3C96), .FIFO_DEPTH(QD)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .bus_type_strap(busType), .rom_width_strap(romWidth),
    .rom_enable_strap(romEnable), .hostAddr(hostAddr), .memCmd(memCmd), .ioCmd(ioCmd),
    .hostWrite(hostWrite), .hostWdata(hostWdata), .ioRdata(ioRdata),
    .ioRdataValid(ioRdataValid), .wide_memory_cycle_indicator(wideInd),
    .cardSelFeedback(cardSel), .bios_rom_select(romSel), .zeroWait(zeroWait),
    .microChannel(microChannel), .cardEnabled(cardEnabled), .memBusFree(memBusFree),
    .memWrValid(memWrValid), .memWrAddr(memWrAddr), .memWrData(memWrData),
    .memWrWide(memWrWide), .scanFetch(scanFetch), .scanIndex(scanIndex),
    .scanLoad(scanLoad), .scanLoadData(scanLoadData), .scanPixel(scanPixel));

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // expected i/o claim worked out independently of the design tables
  function automatic logic ioClaim(input logic [7:0] a, input bit mono);
    case (a[7:4])
      4'hB:    ioClaim = mono && !(a[3:0] inside {4'h6, 4'h7, 4'hC, 4'hD});
      4'hC:    ioClaim = !(a[3:0] inside {4'hA, 4'hB, 4'hD});
      4'hD:    ioClaim = !mono && !(a[3:0] inside {4'h6, 4'h7, 4'hE, 4'hF});
      default: ioClaim = 1'b0;
    endcase
  endfunction

  // straps must stand before release, since they are latched just after it
  task automatic doReset(input bit bt, input bit rw, input bit re);
    rst       = 1'b1;
    busType   = bt;
    romWidth  = rw;
    romEnable = re;
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic mem(input bit wr, input logic [19:0] a, input logic [15:0] d);
    host_u.cycle(1'b1, wr, a, d);
  endtask

  task automatic io(input bit wr, input logic [15:0] a, input logic [15:0] d);
    host_u.cycle(1'b0, wr, {4'h0, a}, d);
  endtask

  // read every address of the three groups and compare the feedback
  task automatic ioSweep(input bit mono);
    logic [15:0] a;
    for (int i = 0; i < 48; i++) begin
      a = 16'h03B0 + 16'(i);
      io(1'b0, a, 16'h0000);
      `CHK("cardSel io", cardSel, ioClaim(a[7:0], mono))
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog sized well above the few hundred cycles the tests need
  initial begin
    #(20 * 20000);
    errors++;
    wrap_up();
  end

  initial begin
    errors = 0;
    num_checks = 0;
    memBusFree = 1'b1;
    scanFetch = 1'b0;
    scanLoad = 1'b0;
    scanIndex = 5'h00;
    scanLoadData = 8'h00;
    doReset(1'b1, 1'b1, 1'b1);
    `CHK("microChannel", microChannel, 1'b0)
    `CHK("cardEnabled", cardEnabled, 1'b1)
    mem(1'b0, 20'hC_0000, 16'h0000);
    `CHK("romSel lo", romSel, 1'b1)
    `CHK("wide rom", wideInd, 1'b1)
    `CHK("cardSel rom", cardSel, 1'b1)
    mem(1'b0, 20'hC_7FFF, 16'h0000);
    `CHK("romSel hi", romSel, 1'b1)
    mem(1'b0, 20'hC_8000, 16'h0000);
    `CHK("romSel out", romSel, 1'b0)
    `CHK("cardSel out", cardSel, 1'b0)
    mem(1'b0, 20'hA_1234, 16'h0000);
    `CHK("wide video", wideInd, 1'b0)
    `CHK("cardSel vid", cardSel, 1'b1)
    @(posedge sys_clk);
    #1 `CHK("cardSel idle", cardSel, 1'b0)
    ioSweep(1'b0);
    io(1'b1, 16'h03C3, 16'h0003);
    ioSweep(1'b1);
    mem(1'b0, 20'hA_0010, 16'h0000);
    `CHK("wide on", wideInd, 1'b1)
    mem(1'b0, 20'hB_0000, 16'h0000);
    `CHK("cardSel mono", cardSel, 1'b1)
    $display("test isa decode done");
    memBusFree = 1'b0;
    for (int i = 0; i <= QD; i++) begin
      mem(1'b1, 20'hA_0000 + 20'(2 * i), 16'h1000 + 16'(i));
      `CHK("zeroWait", zeroWait, (i < QD))
    end
    `CHK("memWr stalled", memWrValid, 1'b0)
    memBusFree = 1'b1;
    n = 0;
    repeat (60) begin
      @(posedge sys_clk);
      #1;
      if (memWrValid === 1'b1) begin
        `CHK("memWrAddr", memWrAddr, 20'hA_0000 + 20'(2 * n))
        `CHK("memWrData", memWrData, 16'h1000 + 16'(n))
        `CHK("memWrWide", memWrWide, 1'b1)
        n++;
      end
    end
    `CHK("drained", n, QD)
    $display("test write queue done");
    for (int i = 0; i < 32; i += 31) begin
      @(posedge sys_clk);
      #1 scanLoad = 1'b1;
      scanIndex = 5'(i);
      scanLoadData = 8'hA0 ^ 8'(i);
    end
    @(posedge sys_clk);
    #1 scanLoad = 1'b0;
    // fetch strobe stays high across both reads, lowered once at the end
    scanFetch = 1'b1;
    for (int i = 0; i < 32; i += 31) begin
      scanIndex = 5'(i);
      @(posedge sys_clk);
      #1 `CHK("scanPixel", scanPixel, 8'hA0 ^ 8'(i))
    end
    scanFetch = 1'b0;
    $display("test cache done");
    doReset(1'b0, 1'b0, 1'b0);
    `CHK("microChannel", microChannel, 1'b1)
    `CHK("cardEn reset", cardEnabled, 1'b0)
    io(1'b0, 16'h0100, 16'h0000);
    `CHK("id low", ioRdata, 8'h96)
    `CHK("id valid", ioRdataValid, 1'b1)
    io(1'b0, 16'h0101, 16'h0000);
    `CHK("id high", ioRdata, 8'h3C)
    io(1'b1, 16'h0102, 16'h0001);
    // enable output follows the control bit one edge after the write lands
    @(posedge sys_clk);
    #1 `CHK("cardEn set", cardEnabled, 1'b1)
    io(1'b0, 16'h0102, 16'h0000);
    `CHK("port102 bit0", ioRdata[0], 1'b1)
    mem(1'b0, 20'hC_0000, 16'h0000);
    `CHK("romSel off", romSel, 1'b0)
    `CHK("wide rom8", wideInd, 1'b0)
    $display("test channel mode done");
    doReset(1'b1, 1'b0, 1'b1);
    mem(1'b0, 20'hC_0000, 16'h0000);
    `CHK("romSel narrow", romSel, 1'b1)
    `CHK("narrow rom", wideInd, 1'b0)
    io(1'b1, 16'h03C3, 16'h0004);
    mem(1'b0, 20'h1_2345, 16'h0000);
    `CHK("cardSel linear", cardSel, 1'b1)
    `CHK("linear narrow", wideInd, 1'b0)
    io(1'b0, 16'h03C3, 16'h0000);
    `CHK("mode readback", ioRdata, 8'h04)
    `CHK("mode valid", ioRdataValid, 1'b1)
    $display("test rom width and linear done");
    wrap_up();
  end
endmodule
